// [cca_pkg.sv]
package cca_pkg;

  localparam int CCA_MODULES = 6;
  localparam int CCA_WDT_MODULE = 5;

  localparam logic [7:0] CCA_CNT_LO_ADDR = 8'hF9;
  localparam logic [7:0] CCA_CNT_HI_ADDR = 8'hFA;
  localparam logic [7:0] CCA_PWM_CFG_ADDR = 8'hDF;
  localparam logic [7:0] CCA_MODE_ADDR [0:5] = '{8'hDA, 8'hDB, 8'hDC, 8'hDD, 8'hDE, 8'hCE};
  localparam logic [7:0] CCA_CAP_LO_ADDR [0:5] = '{8'hFB, 8'hE9, 8'hEB, 8'hED, 8'hFD, 8'hD2};
  localparam logic [7:0] CCA_CAP_HI_ADDR [0:5] = '{8'hFC, 8'hEA, 8'hEC, 8'hEE, 8'hFE, 8'hD3};

  // mode byte fields
  localparam int CCA_LONG_BIT = 7;
  localparam int CCA_COMPARE_BIT = 6;
  localparam int CCA_RISE_BIT = 5;
  localparam int CCA_FALL_BIT = 4;
  localparam int CCA_MATCH_BIT = 3;
  localparam int CCA_TOGGLE_BIT = 2;
  localparam int CCA_PWM_BIT = 1;
  localparam int CCA_IRQ_BIT = 0;

  // modulation config fields; other bits read as zero
  localparam int CCA_RELOAD_ACCESS_SELECT_BIT = 7;
  localparam int CCA_CYCLE_LENGTH_SELECT_LSB = 0;
  localparam logic [7:0] CCA_PWM_CFG_MASK = 8'h83;

  localparam logic [7:0] CCA_BYTE_RST = 8'h00;
  localparam logic [15:0] CCA_WORD_RST = 16'h0000;
  localparam logic [15:0] CCA_ONE = 16'h0001;
  localparam logic [15:0] CCA_FULL_MASK = 16'hFFFF;
  localparam logic [15:0] CCA_BYTE_MASK = 16'h00FF;

  typedef enum logic [4:0] {
    CCA_FN_IDLE = 5'h01,
    CCA_FN_TOGGLE = 5'h02,
    CCA_FN_PWM = 5'h04,
    CCA_FN_PWM16 = 5'h08,
    CCA_FN_FREQ = 5'h10
  } cca_func_e;

  function automatic logic [15:0] cca_cycle_mask(input logic [1:0] sel);
    case (sel)
      2'h0: return 16'h00FF;
      2'h1: return 16'h01FF;
      2'h2: return 16'h03FF;
      default: return 16'h07FF;
    endcase
  endfunction

endpackage

// [cca_channel.sv]
`timescale 1ns/100ps
`default_nettype none
module cca_channel (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_wr_mode,
  input wire logic i_wr_lo,
  input wire logic i_wr_hi,
  input wire logic [7:0] i_wdata,
  input wire logic i_reload_access_select,
  input wire logic [1:0] i_cycle_length_select,
  input wire logic [15:0] i_cnt,
  input wire logic i_step,
  input wire logic i_pin,
  input wire logic i_flag_clr,
  output logic [7:0] o_mode,
  output logic [7:0] o_rd_lo,
  output logic [7:0] o_rd_hi,
  output logic o_pin,
  output logic o_flag,
  output logic o_irq,
  output logic o_match
);
  import cca_pkg::*;

  logic [7:0] mode_reg;
  logic [7:0] mode_next;
  logic [15:0] ccr_reg;
  logic [15:0] ccr_next;
  logic [15:0] reload_reg;
  logic pin_prev_reg;
  logic out_reg;
  logic out_next;
  logic flag_reg;
  logic irq_reg;
  logic match_reg;
  cca_func_e func;
  wire logic [15:0] cyc_mask = cca_cycle_mask(i_cycle_length_select);
  wire logic pwm_on = mode_reg[CCA_PWM_BIT];
  wire logic tog_on = mode_reg[CCA_TOGGLE_BIT];

  assign func = cca_func_e'((pwm_on && tog_on) ? CCA_FN_FREQ :
    (pwm_on && mode_reg[CCA_LONG_BIT]) ? CCA_FN_PWM16 :
    pwm_on ? CCA_FN_PWM :
    tog_on ? CCA_FN_TOGGLE : CCA_FN_IDLE);

  wire logic [15:0] cmp_mask = (func == CCA_FN_PWM) ? cyc_mask :
    (func == CCA_FN_FREQ) ? CCA_BYTE_MASK : CCA_FULL_MASK;
  wire logic cnt_eq = ((i_cnt ^ ccr_reg) & cmp_mask) == CCA_WORD_RST;
  // match counted once per new counter value, only with comparator on
  wire logic match_evt = mode_reg[CCA_COMPARE_BIT] && i_step && cnt_eq;
  wire logic cyc_wrap = i_step && ((i_cnt & cyc_mask) == CCA_WORD_RST);
  wire logic rise_evt = i_pin && !pin_prev_reg && mode_reg[CCA_RISE_BIT];
  wire logic fall_evt = !i_pin && pin_prev_reg && mode_reg[CCA_FALL_BIT];
  wire logic cap_evt = rise_evt || fall_evt;
  wire logic flag_set = cap_evt || (match_evt && mode_reg[CCA_MATCH_BIT]);
  wire logic sw_ccr_wr = (i_wr_lo || i_wr_hi) && !i_reload_access_select;
  // 8-bit cycle reloads the low byte from the high byte, longer ones from reload
  wire logic [15:0] reload_src = (i_cycle_length_select == 2'h0) ? {8'h00, ccr_reg[15:8]} : reload_reg;
  wire logic [7:0] freq_next = ccr_reg[7:0] + ccr_reg[15:8];

  assign mode_next = i_wr_mode ? i_wdata :
    i_wr_lo ? (mode_reg & ~(8'h01 << CCA_COMPARE_BIT)) :
    i_wr_hi ? (mode_reg | (8'h01 << CCA_COMPARE_BIT)) : mode_reg;

  always_comb
  begin
    ccr_next = ccr_reg;
    if (sw_ccr_wr)
    begin
      if (i_wr_lo)
        ccr_next[7:0] = i_wdata;
      else
        ccr_next[15:8] = i_wdata;
    end
    else if (cap_evt)
      ccr_next = i_cnt;
    else if (func == CCA_FN_PWM && cyc_wrap)
      ccr_next = (ccr_reg & ~cyc_mask) | (reload_src & cyc_mask);
    else if (func == CCA_FN_FREQ && match_evt)
      ccr_next[7:0] = freq_next;
  end

  always_comb
  begin
    out_next = out_reg;
    case (func)
      CCA_FN_TOGGLE, CCA_FN_FREQ: out_next = match_evt ? !out_reg : out_reg;
      CCA_FN_PWM: out_next = mode_reg[CCA_COMPARE_BIT] ?
        ((i_cnt & cyc_mask) < (ccr_reg & cyc_mask)) : out_reg;
      CCA_FN_PWM16: out_next = mode_reg[CCA_COMPARE_BIT] ? (i_cnt < ccr_reg) : out_reg;
      CCA_FN_IDLE: out_next = out_reg;
      default: out_next = out_reg;
    endcase
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      mode_reg <= CCA_BYTE_RST;
      ccr_reg <= CCA_WORD_RST;
      reload_reg <= CCA_WORD_RST;
      pin_prev_reg <= 1'b0;
      out_reg <= 1'b0;
      flag_reg <= 1'b0;
      irq_reg <= 1'b0;
      match_reg <= 1'b0;
    end
    else
    begin
      mode_reg <= mode_next;
      ccr_reg <= ccr_next;
      if (i_reload_access_select && i_wr_lo)
        reload_reg[7:0] <= i_wdata;
      if (i_reload_access_select && i_wr_hi)
        reload_reg[15:8] <= i_wdata;
      pin_prev_reg <= i_pin;
      out_reg <= out_next;
      // a new event wins over a clear in the same cycle
      flag_reg <= flag_set || (flag_reg && !i_flag_clr);
      irq_reg <= flag_reg && mode_reg[CCA_IRQ_BIT];
      match_reg <= match_evt;
    end
  end

  assign o_mode = mode_reg;
  assign o_rd_lo = i_reload_access_select ? reload_reg[7:0] : ccr_reg[7:0];
  assign o_rd_hi = i_reload_access_select ? reload_reg[15:8] : ccr_reg[15:8];
  assign o_pin = out_reg;
  assign o_flag = flag_reg;
  assign o_irq = irq_reg;
  assign o_match = match_reg;

  property p_irq_mask;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    flag_set && mode_reg[CCA_IRQ_BIT] && !i_wr_mode |=> ##1 irq_reg;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("enabled flag did not raise interrupt");

  property p_capture;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    cap_evt && !sw_ccr_wr |=> (ccr_reg == $past(i_cnt)) && flag_reg;
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture did not copy counter or set flag");

  property p_toggle;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (func == CCA_FN_TOGGLE) && match_evt |=> out_reg != $past(out_reg);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("output did not toggle on match");

  property p_match_flag;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    match_evt && mode_reg[CCA_MATCH_BIT] |=> flag_reg ##1 irq_reg == $past(mode_reg[CCA_IRQ_BIT]);
  endproperty
  a_match_flag: assert property (p_match_flag)
    else $error("match did not set flag");

  property p_pwm16;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (func == CCA_FN_PWM16) && mode_reg[CCA_COMPARE_BIT] |=> out_reg == ($past(i_cnt) < $past(ccr_reg));
  endproperty
  a_pwm16: assert property (p_pwm16)
    else $error("16-bit width modulation level wrong");

endmodule // cca_channel
`default_nettype wire

// [cca_top.sv]
`timescale 1ns/100ps
`default_nettype none
module cca_top (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_watchdog_enable,
  input wire logic i_count_tick,
  input wire logic [cca_pkg::CCA_MODULES-1:0] i_capture_pin,
  input wire logic [cca_pkg::CCA_MODULES-1:0] i_flag_clear,
  output logic [7:0] o_sfr_rdata,
  output logic [cca_pkg::CCA_MODULES-1:0] o_module_output_pin,
  output logic [cca_pkg::CCA_MODULES-1:0] o_capture_compare_flag,
  output logic [cca_pkg::CCA_MODULES-1:0] o_module_irq,
  output logic o_watchdog_expire
);
  import cca_pkg::*;

  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic [7:0] snap_reg;
  logic step_reg;
  logic [7:0] pwm_cfg_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic wdt_exp_reg;

  logic [7:0] mode_w [0:CCA_MODULES-1];
  logic [7:0] rd_lo_w [0:CCA_MODULES-1];
  logic [7:0] rd_hi_w [0:CCA_MODULES-1];
  logic [CCA_MODULES-1:0] match_w;
  logic [CCA_MODULES-1:0] wr_mode;
  logic [CCA_MODULES-1:0] wr_lo;
  logic [CCA_MODULES-1:0] wr_hi;

  wire logic wdt_on = i_watchdog_enable;
  wire logic hit_cnt_lo = i_sfr_addr == CCA_CNT_LO_ADDR;
  wire logic hit_cnt_hi = i_sfr_addr == CCA_CNT_HI_ADDR;
  wire logic hit_cfg = i_sfr_addr == CCA_PWM_CFG_ADDR;
  // counter bytes are frozen against software while the watchdog runs
  wire logic wr_cnt_lo = i_sfr_wr && hit_cnt_lo && !wdt_on;
  wire logic wr_cnt_hi = i_sfr_wr && hit_cnt_hi && !wdt_on;
  wire logic rd_cnt_lo = i_sfr_rd && hit_cnt_lo;
  wire logic rd_cnt_hi = i_sfr_rd && hit_cnt_hi;
  wire logic wr_cfg = i_sfr_wr && hit_cfg;
  wire logic reload_access_select = pwm_cfg_reg[CCA_RELOAD_ACCESS_SELECT_BIT];
  wire logic [1:0] cycle_length_select = pwm_cfg_reg[CCA_CYCLE_LENGTH_SELECT_LSB +: 2];
  wire logic [7:0] cnt_hi = cnt_reg[15:8];

  // software write takes the cycle over a timebase tick
  assign cnt_next = wr_cnt_lo ? {cnt_reg[15:8], i_sfr_wdata} :
    wr_cnt_hi ? {i_sfr_wdata, cnt_reg[7:0]} :
    i_count_tick ? (cnt_reg + CCA_ONE) : cnt_reg;

  genvar g;
  generate
    for (g = 0; g < CCA_MODULES; g++)
    begin : g_mod
      wire logic hit_mode = i_sfr_addr == CCA_MODE_ADDR[g];
      wire logic locked = (g == CCA_WDT_MODULE) && wdt_on;
      assign wr_mode[g] = i_sfr_wr && hit_mode && !locked;
      assign wr_lo[g] = i_sfr_wr && (i_sfr_addr == CCA_CAP_LO_ADDR[g]);
      assign wr_hi[g] = i_sfr_wr && (i_sfr_addr == CCA_CAP_HI_ADDR[g]);

      cca_channel u_chan (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_wr_mode(wr_mode[g]),
        .i_wr_lo(wr_lo[g]),
        .i_wr_hi(wr_hi[g]),
        .i_wdata(i_sfr_wdata),
        .i_reload_access_select(reload_access_select),
        .i_cycle_length_select(cycle_length_select),
        .i_cnt(cnt_reg),
        .i_step(step_reg),
        .i_pin(i_capture_pin[g]),
        .i_flag_clr(i_flag_clear[g]),
        .o_mode(mode_w[g]),
        .o_rd_lo(rd_lo_w[g]),
        .o_rd_hi(rd_hi_w[g]),
        .o_pin(o_module_output_pin[g]),
        .o_flag(o_capture_compare_flag[g]),
        .o_irq(o_module_irq[g]),
        .o_match(match_w[g])
      );

      property p_mode_lock;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        i_sfr_wr && hit_mode && locked |=> mode_w[g] == $past(mode_w[g]);
      endproperty
      a_mode_lock: assert property (p_mode_lock)
        else $error("locked mode byte changed on write");

      property p_low_clears;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        wr_lo[g] |=> !mode_w[g][CCA_COMPARE_BIT];
      endproperty
      a_low_clears: assert property (p_low_clears)
        else $error("low capture write left compare enabled");

      property p_high_sets;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        wr_hi[g] |=> mode_w[g][CCA_COMPARE_BIT];
      endproperty
      a_high_sets: assert property (p_high_sets)
        else $error("high capture write left compare disabled");

      property p_reload_alias;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        wr_lo[g] && !wr_cfg |=> rd_lo_w[g] == $past(i_sfr_wdata);
      endproperty
      a_reload_alias: assert property (p_reload_alias)
        else $error("low capture byte did not reach selected register");
    end
  endgenerate

  always_comb
  begin
    rdata_next = CCA_BYTE_RST;
    if (hit_cnt_lo)
      rdata_next = cnt_reg[7:0];
    else if (hit_cnt_hi)
      rdata_next = snap_reg;
    else if (hit_cfg)
      rdata_next = pwm_cfg_reg;
    for (int i = 0; i < CCA_MODULES; i++)
    begin
      if (i_sfr_addr == CCA_MODE_ADDR[i])
        rdata_next = mode_w[i];
      if (i_sfr_addr == CCA_CAP_LO_ADDR[i])
        rdata_next = rd_lo_w[i];
      if (i_sfr_addr == CCA_CAP_HI_ADDR[i])
        rdata_next = rd_hi_w[i];
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      cnt_reg <= CCA_WORD_RST;
      snap_reg <= CCA_BYTE_RST;
      step_reg <= 1'b0;
      pwm_cfg_reg <= CCA_BYTE_RST;
      rdata_reg <= CCA_BYTE_RST;
      wdt_exp_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      // channel match and cycle wrap events fire only on a freshly changed counter
      step_reg <= cnt_next != cnt_reg;
      if (rd_cnt_lo)
        snap_reg <= cnt_reg[15:8];
      if (wr_cfg)
        pwm_cfg_reg <= i_sfr_wdata & CCA_PWM_CFG_MASK;
      if (i_sfr_rd)
        rdata_reg <= rdata_next;
      wdt_exp_reg <= wdt_on && match_w[CCA_WDT_MODULE];
    end
  end

  assign o_sfr_rdata = rdata_reg;
  assign o_watchdog_expire = wdt_exp_reg;

  property p_cnt_lock;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    wdt_on && i_sfr_wr && (hit_cnt_lo || hit_cnt_hi) && !i_count_tick
      |=> cnt_reg == $past(cnt_reg);
  endproperty
  a_cnt_lock: assert property (p_cnt_lock)
    else $error("counter changed by write under watchdog");

  property p_cnt_write;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    wr_cnt_lo |=> cnt_reg[7:0] == $past(i_sfr_wdata);
  endproperty
  a_cnt_write: assert property (p_cnt_write)
    else $error("counter low byte write lost");

  property p_count_step;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    i_count_tick && !wr_cnt_lo && !wr_cnt_hi |=> cnt_reg == $past(cnt_reg) + CCA_ONE;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("counter did not step on tick");

  property p_count_hold;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    !i_count_tick && !wr_cnt_lo && !wr_cnt_hi |=> !step_reg ##0 cnt_reg == $past(cnt_reg);
  endproperty
  a_count_hold: assert property (p_count_hold)
    else $error("counter moved without tick");

  property p_snap_load;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    rd_cnt_lo |=> snap_reg == $past(cnt_hi);
  endproperty
  a_snap_load: assert property (p_snap_load)
    else $error("snapshot not loaded on low byte read");

  property p_snap_read;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    rd_cnt_hi |=> o_sfr_rdata == $past(snap_reg);
  endproperty
  a_snap_read: assert property (p_snap_read)
    else $error("high byte read did not return snapshot");

  property p_snap_hold;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    !rd_cnt_lo [*2] |=> $stable(snap_reg);
  endproperty
  a_snap_hold: assert property (p_snap_hold)
    else $error("snapshot changed without low byte read");

endmodule // cca_top
`default_nettype wire

// [cca_pin_model.sv]
`timescale 1ns/100ps
`default_nettype none
module cca_pin_model (
  input wire logic i_ref_clk,
  input wire logic [cca_pkg::CCA_MODULES-1:0] i_level,
  input wire logic [cca_pkg::CCA_MODULES-1:0] i_pin_out,
  output logic [cca_pkg::CCA_MODULES-1:0] o_capture_pin,
  output logic [15:0] o_toggles
);
  import cca_pkg::*;
  logic last_pin;
  initial
  begin
    o_capture_pin = '0;
    o_toggles = 16'h0000;
    last_pin = 1'b0;
  end
  // levels move only on clock edges, so the block sees clean synchronous inputs
  always @(posedge i_ref_clk)
  begin
    o_capture_pin <= i_level;
    last_pin <= i_pin_out[0];
    if (i_pin_out[0] !== last_pin)
    begin
      o_toggles <= o_toggles + 16'h0001;
    end
  end
endmodule // cca_pin_model
`default_nettype wire

// [testbench.sv]
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import cca_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] i_sfr_addr = 8'h00;
  logic i_sfr_wr = 1'b0;
  logic i_sfr_rd = 1'b0;
  logic [7:0] i_sfr_wdata = 8'h00;
  logic i_watchdog_enable = 1'b0;
  logic i_count_tick = 1'b0;
  logic [5:0] i_flag_clear = 6'h00;
  logic [5:0] pin_level = 6'h00;
  logic [5:0] capture_pin;
  logic [7:0] o_sfr_rdata;
  logic [5:0] o_module_output_pin;
  logic [5:0] o_capture_compare_flag;
  logic [5:0] o_module_irq;
  logic o_watchdog_expire;
  logic [15:0] toggles;
  logic [15:0] t0;
  logic [5:0] pins0;
  logic wd_seen = 1'b0;
  logic [7:0] match_mode [0:2] = '{8'h4D, 8'h48, 8'h08};
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;

  always #25 i_ref_clk = ~i_ref_clk;

  cca_top uut (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_sfr_addr(i_sfr_addr),
    .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd), .i_sfr_wdata(i_sfr_wdata),
    .i_watchdog_enable(i_watchdog_enable), .i_count_tick(i_count_tick),
    .i_capture_pin(capture_pin), .i_flag_clear(i_flag_clear),
    .o_sfr_rdata(o_sfr_rdata), .o_module_output_pin(o_module_output_pin),
    .o_capture_compare_flag(o_capture_compare_flag), .o_module_irq(o_module_irq),
    .o_watchdog_expire(o_watchdog_expire)
  );

  cca_pin_model pins (
    .i_ref_clk(i_ref_clk), .i_level(pin_level), .i_pin_out(o_module_output_pin),
    .o_capture_pin(capture_pin), .o_toggles(toggles)
  );

  task automatic end_of_test();
    if (mismatches == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge i_ref_clk)
  begin
    cycles++;
    if (o_watchdog_expire === 1'b1)
      wd_seen <= 1'b1;
    // whole sequence needs well under 2000 cycles
    if (cycles == 6000)
    begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask

  // strobes drop one cycle before the next request to keep one change per step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_sfr_addr = a;
    i_sfr_wdata = d;
    i_sfr_wr = 1'b1;
    cyc(1);
    i_sfr_wr = 1'b0;
    cyc(1);
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    i_sfr_addr = a;
    i_sfr_rd = 1'b1;
    cyc(1);
    i_sfr_rd = 1'b0;
    chk(what, {8'h00, o_sfr_rdata}, {8'h00, exp});
    cyc(1);
  endtask

  task automatic tick(input int n);
    i_count_tick = 1'b1;
    cyc(n);
    i_count_tick = 1'b0;
    cyc(1);
  endtask

  task automatic set_count(input logic [15:0] v);
    wr(CCA_CNT_LO_ADDR, v[7:0]);
    wr(CCA_CNT_HI_ADDR, v[15:8]);
  endtask

  task automatic set_ccr(input int m, input logic [15:0] v);
    wr(CCA_CAP_LO_ADDR[m], v[7:0]);
    wr(CCA_CAP_HI_ADDR[m], v[15:8]);
  endtask

  task automatic clear_flags();
    i_flag_clear = 6'h3F;
    cyc(1);
    i_flag_clear = 6'h00;
    cyc(1);
  endtask

  initial
  begin
    cyc(20);
    i_rst_n = 1'b1;
    rdchk("cnt_lo_reset", CCA_CNT_LO_ADDR, 8'h00);
    rdchk("cnt_hi_reset", CCA_CNT_HI_ADDR, 8'h00);
    rdchk("unmapped", 8'h00, 8'h00);
    for (int m = 0; m < CCA_MODULES; m++)
    begin
      rdchk("mode_reset", CCA_MODE_ADDR[m], 8'h00);
      rdchk("cap_lo_reset", CCA_CAP_LO_ADDR[m], 8'h00);
      wr(CCA_MODE_ADDR[m], 8'hA5 ^ 8'(m));
      rdchk("mode_rw", CCA_MODE_ADDR[m], 8'hA5 ^ 8'(m));
    end
    set_count(16'h1234);
    rdchk("cnt_lo", CCA_CNT_LO_ADDR, 8'h34);
    wr(CCA_CNT_HI_ADDR, 8'h56);
    rdchk("snapshot_old", CCA_CNT_HI_ADDR, 8'h12);
    rdchk("cnt_lo", CCA_CNT_LO_ADDR, 8'h34);
    rdchk("snapshot_new", CCA_CNT_HI_ADDR, 8'h56);
    set_count(16'hFFFF);
    tick(1);
    rdchk("wrap_lo", CCA_CNT_LO_ADDR, 8'h00);
    rdchk("wrap_hi", CCA_CNT_HI_ADDR, 8'h00);
    wr(CCA_MODE_ADDR[1], 8'h48);
    wr(CCA_CAP_LO_ADDR[1], 8'h11);
    rdchk("lo_clears_cmp", CCA_MODE_ADDR[1], 8'h08);
    wr(CCA_CAP_HI_ADDR[1], 8'h22);
    rdchk("hi_sets_cmp", CCA_MODE_ADDR[1], 8'h48);
    wr(CCA_PWM_CFG_ADDR, 8'h80);
    wr(CCA_CAP_LO_ADDR[1], 8'h77);
    rdchk("reload_lo", CCA_CAP_LO_ADDR[1], 8'h77);
    wr(CCA_PWM_CFG_ADDR, 8'h00);
    rdchk("ccr_lo_kept", CCA_CAP_LO_ADDR[1], 8'h11);
    // match: module 0 toggles and interrupts, 1 flags only, 2 lacks compare
    for (int m = 0; m < 3; m++)
    begin
      set_ccr(m, 16'h0005);
      wr(CCA_MODE_ADDR[m], match_mode[m]);
    end
    set_count(16'h0000);
    clear_flags();
    pins0 = o_module_output_pin;
    tick(4);
    cyc(3);
    chk("flag_early", {13'h0000, o_capture_compare_flag[2:0]}, 16'h0000);
    tick(1);
    cyc(3);
    chk("flag_match", {13'h0000, o_capture_compare_flag[2:0]}, 16'h0003);
    chk("irq_mask", {14'h0000, o_module_irq[1:0]}, 16'h0001);
    chk("toggle", {14'h0000, o_module_output_pin[1:0]}, {14'h0000, pins0[1:0] ^ 2'h1});
    // watchdog: module 5 locked, counter locked, expiry on match
    set_ccr(5, 16'h0005);
    wr(CCA_MODE_ADDR[5], 8'h48);
    set_count(16'h0000);
    i_watchdog_enable = 1'b1;
    wr(CCA_MODE_ADDR[5], 8'h00);
    rdchk("wd_mode_lock", CCA_MODE_ADDR[5], 8'h48);
    wr(CCA_CNT_LO_ADDR, 8'h55);
    rdchk("wd_cnt_lock", CCA_CNT_LO_ADDR, 8'h00);
    tick(5);
    cyc(3);
    chk("wd_expire", {15'h0000, wd_seen}, 16'h0001);
    i_watchdog_enable = 1'b0;
    // capture: module 3 rising only, module 4 falling only
    wr(CCA_MODE_ADDR[3], 8'h20);
    wr(CCA_MODE_ADDR[4], 8'h10);
    pin_level = 6'h10;
    cyc(3);
    clear_flags();
    set_count(16'h0123);
    pin_level = 6'h08;
    cyc(3);
    chk("cap_flags", {14'h0000, o_capture_compare_flag[4:3]}, 16'h0003);
    rdchk("cap_rise", CCA_CAP_LO_ADDR[3], 8'h23);
    rdchk("cap_fall", CCA_CAP_LO_ADDR[4], 8'h23);
    wr(CCA_CNT_LO_ADDR, 8'h45);
    pin_level = 6'h00;
    cyc(3);
    rdchk("no_cap_fall", CCA_CAP_LO_ADDR[3], 8'h23);
    // capture edge and flag clear in the same cycle: the edge must win
    clear_flags();
    pin_level = 6'h08;
    cyc(1);
    i_flag_clear = 6'h08;
    cyc(1);
    i_flag_clear = 6'h00;
    cyc(2);
    chk("set_wins", {15'h0000, o_capture_compare_flag[3]}, 16'h0001);
    // pwm on module 0 with compare 0x8040
    set_ccr(0, 16'h8040);
    wr(CCA_MODE_ADDR[0], 8'h42);
    set_count(16'h9110);
    cyc(3);
    chk("pwm8", {15'h0000, o_module_output_pin[0]}, 16'h0001);
    wr(CCA_PWM_CFG_ADDR, 8'h01);
    wr(CCA_CNT_HI_ADDR, 8'h91);
    cyc(3);
    chk("pwm9", {15'h0000, o_module_output_pin[0]}, 16'h0000);
    wr(CCA_PWM_CFG_ADDR, 8'h00);
    wr(CCA_MODE_ADDR[0], 8'hC2);
    wr(CCA_CNT_HI_ADDR, 8'h91);
    cyc(3);
    chk("pwm16_low", {15'h0000, o_module_output_pin[0]}, 16'h0000);
    wr(CCA_CNT_HI_ADDR, 8'h70);
    cyc(3);
    chk("pwm16_high", {15'h0000, o_module_output_pin[0]}, 16'h0001);
    // frequency output: step 4 gives a toggle every 4 counts
    set_count(16'h0000);
    set_ccr(0, 16'h0404);
    wr(CCA_MODE_ADDR[0], 8'h46);
    cyc(2);
    t0 = toggles;
    tick(20);
    cyc(3);
    chk("freq_toggles", toggles - t0, 16'h0005);
    // 9-bit pwm on module 1: cycle wrap loads compare low bits from reload
    wr(CCA_PWM_CFG_ADDR, 8'h81);
    set_ccr(1, 16'h0133);
    wr(CCA_PWM_CFG_ADDR, 8'h01);
    wr(CCA_MODE_ADDR[1], 8'h42);
    set_count(16'h01FF);
    tick(1);
    rdchk("reload9_lo", CCA_CAP_LO_ADDR[1], 8'h33);
    rdchk("reload9_hi", CCA_CAP_HI_ADDR[1], 8'h01);
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
